// *** logic/qdc_defines.svh ***
// constants shared by the quad converter command decoder
`ifndef QDC_DEFINES_SVH
`define QDC_DEFINES_SVH

// frame and field layout
`define QDC_FRAME_BITS 16
`define QDC_DATA_W 12
`define QDC_CHANNELS 4
`define QDC_PD_ALL_BIT 11
`define QDC_PD_CH_HI 10
`define QDC_PD_CH_LO 9
`define QDC_PD_TERM_HI 8
`define QDC_PD_TERM_LO 7

// load control codes
`define QDC_LD_STORE 2'h0
`define QDC_LD_XFER 2'h1
`define QDC_LD_BOTH 2'h2
`define QDC_LD_BCAST 2'h3

// channel select codes under broadcast
`define QDC_BC_STORE 2'h0
`define QDC_BC_XFER 2'h1
`define QDC_BC_BOTH 2'h2
`define QDC_BC_PWD 2'h3

// termination codes of a power-down command
`define QDC_TERM_HIZ 2'h0
`define QDC_TERM_1K 2'h1
`define QDC_TERM_100K 2'h2

// apb register map
`define QDC_ADDR_W 12
`define QDC_OFS_CTRL 12'h000
`define QDC_OFS_STATUS 12'h004
`define QDC_OFS_FRAMES 12'h008
`define QDC_OFS_PDSTATE 12'h00C
`define QDC_OFS_INREG0 12'h010
`define QDC_OFS_DACREG0 12'h020
`define QDC_CH_MASK 12'h00C
`define QDC_CH_LSB 2
`define QDC_CTRL_EN_BIT 0
`define QDC_CTRL_RST 1'h1
`define QDC_STAT_BUSY_BIT 0
`define QDC_STAT_PD_BIT 1
`define QDC_CNT_HALF 16
`define QDC_PD_FIELD_W 4

`endif

// *** logic/qdc_pkg.sv ***
// types of the quad converter command decoder
`default_nettype none
`include "qdc_defines.svh"

package qdc_pkg;

    typedef logic [`QDC_DATA_W-1:0] qdc_code_t;

    // one serial command as it arrives, msb first
    typedef struct packed {
        logic load_ctrl_hi;
        logic load_ctrl_lo;
        logic chan_pick_hi;
        logic chan_pick_lo;
        qdc_code_t payload_bits;
    } qdc_cmd_t;

    // output state of one channel
    typedef enum logic [3:0] {
        QDC_PD_ACTIVE = 4'h1,
        QDC_PD_HIZ = 4'h2,
        QDC_PD_1K = 4'h4,
        QDC_PD_100K = 4'h8
    } qdc_pd_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`QDC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } qdc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } qdc_apb_rsp_t;

endpackage

`default_nettype wire

// *** logic/qdc_sync.sv ***
// two flip-flop level synchroniser
`default_nettype none

module qdc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,            // destination clock
    input wire logic rst_n,          // async reset, active low
    input wire logic [WIDTH-1:0] d,  // level from the other domain
    output logic [WIDTH-1:0] q       // synchronised level
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // first stage feeds only the second
    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end

endmodule

`default_nettype wire

// *** logic/qdc_top.sv ***
// serial command decoder with double-buffered channel registers and apb view
//
// Local design decisions: the APB register port and the placing of the registers.
`default_nettype none
`include "qdc_defines.svh"

// Notes on behaviour
// [RULE1] load 00 stores payload in chosen input register
// [RULE2] load 01 copies input to converter register
// [RULE3] load 10 writes both registers at once
// [RULE4] load 11 broadcasts store, transfer or both
// [RULE5] load 11 select 11 is power-down
// [RULE6] write-only three-wire link, no read-back
// [RULE7] frame sync falling edge starts frame
// [RULE8] power-down payload picks channels and termination
// [RULE9] sixteen bits msb first, act after last
module qdc_top #(
    parameter int CHANNELS = `QDC_CHANNELS,
    parameter int DATA_W = `QDC_DATA_W,
    parameter int FRAME_BITS = `QDC_FRAME_BITS
) (
    input wire logic pclk,                                    // register clock
    input wire logic presetn,                                 // async reset, active low
    input wire qdc_pkg::qdc_apb_req_t apb_req,                // apb request
    output qdc_pkg::qdc_apb_rsp_t apb_rsp,                    // apb answer
    input wire logic sclk,                                    // serial link clock
    input wire logic sdata,                                   // serial data in
    input wire logic frame_sync_n,                            // frame sync, active low
    output qdc_pkg::qdc_code_t [CHANNELS-1:0] dac_code,       // converter register codes
    output qdc_pkg::qdc_pd_t [CHANNELS-1:0] power_down,       // output state per channel
    output logic [CHANNELS-1:0] out_update                    // converter register loaded
);
    import qdc_pkg::*;

    localparam int CNT_W = $clog2(FRAME_BITS + 1);

    // elaboration checks
    if (CHANNELS != `QDC_CHANNELS) begin : g_bad_ch
        $error("qdc_top: two select bits serve exactly four channels");
    end
    if (DATA_W != `QDC_DATA_W) begin : g_bad_w
        $error("qdc_top: payload width is fixed by the command layout");
    end
    if (FRAME_BITS != $bits(qdc_cmd_t)) begin : g_bad_f
        $error("qdc_top: frame length must equal the command width");
    end

    // ---------------- link domain (sclk) ----------------
    logic link_rst_n;
    logic [CNT_W-1:0] bit_cnt;
    logic [CNT_W-1:0] next_bit_cnt;
    logic [FRAME_BITS-1:0] shift;
    logic [FRAME_BITS-1:0] next_shift;
    logic frame_done;
    logic [FRAME_BITS-1:0] hold;
    logic [FRAME_BITS-1:0] next_hold;
    logic link_tgl;
    logic next_link_tgl;

    // idle frame sync holds the bit counter cleared
    // [RULE7] frame start clears counter
    assign link_rst_n = presetn & ~frame_sync_n;

    // shift msb first on falling edges, saturate after a full frame
    // [RULE9] sixteen bit shifter
    always_comb begin
        next_shift = {shift[FRAME_BITS-2:0], sdata};
        next_bit_cnt = bit_cnt;
        if (bit_cnt != CNT_W'(FRAME_BITS)) begin
            next_bit_cnt = bit_cnt + CNT_W'(1);
        end
    end

    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt <= '0;
            shift <= '0;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
        end
    end

    // the sixteenth bit completes the command; extra bits are dropped
    // [RULE9] act after last bit
    assign frame_done = (bit_cnt == CNT_W'(FRAME_BITS - 1));

    always_comb begin
        next_hold = hold;
        next_link_tgl = link_tgl;
        if (frame_done) begin
            next_hold = next_shift;
            next_link_tgl = ~link_tgl;
        end
    end

    // hold stays put for a whole frame, so the toggle qualifies it
    always_ff @(negedge sclk or negedge presetn) begin
        if (!presetn) begin
            hold <= '0;
            link_tgl <= 1'b0;
        end else begin
            hold <= next_hold;
            link_tgl <= next_link_tgl;
        end
    end

    // ---------------- register domain (pclk) ----------------
    logic tgl_sync;
    logic busy_sync_n;
    logic tgl_seen;
    logic cmd_strobe;
    logic ctrl_en;
    logic next_ctrl_en;
    logic [`QDC_CNT_HALF-1:0] applied_cnt;
    logic [`QDC_CNT_HALF-1:0] next_applied_cnt;
    logic [`QDC_CNT_HALF-1:0] dropped_cnt;
    logic [`QDC_CNT_HALF-1:0] next_dropped_cnt;
    qdc_cmd_t cmd;
    qdc_code_t [CHANNELS-1:0] in_reg;
    qdc_code_t [CHANNELS-1:0] next_in_reg;
    qdc_code_t [CHANNELS-1:0] next_dac_code;
    qdc_pd_t [CHANNELS-1:0] next_power_down;
    logic [CHANNELS-1:0] next_out_update;

    // command toggle crossing
    qdc_sync #(
        .WIDTH(1),
        .RST_VAL(1'b0)
    ) u_tgl_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(link_tgl),
        .q(tgl_sync)
    );

    // frame sync level for the busy flag
    qdc_sync #(
        .WIDTH(1),
        .RST_VAL(1'b1)
    ) u_busy_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(frame_sync_n),
        .q(busy_sync_n)
    );

    assign cmd_strobe = tgl_sync ^ tgl_seen;
    assign cmd = qdc_cmd_t'(hold);

    // maps a termination code to the output state
    // [RULE8] termination decode
    function automatic qdc_pd_t term_to_pd(input logic [1:0] term);
        qdc_pd_t pd;
        case (term)
            `QDC_TERM_1K: begin
                pd = QDC_PD_1K;
            end
            `QDC_TERM_100K: begin
                pd = QDC_PD_100K;
            end
            default: begin
                pd = QDC_PD_HIZ;
            end
        endcase
        return pd;
    endfunction

    // command execution on the channel registers
    always_comb begin
        logic [1:0] ld;
        logic [1:0] sel;
        logic hit;
        ld = {cmd.load_ctrl_hi, cmd.load_ctrl_lo};
        sel = {cmd.chan_pick_hi, cmd.chan_pick_lo};
        hit = 1'b0;
        next_in_reg = in_reg;
        next_dac_code = dac_code;
        next_power_down = power_down;
        next_out_update = '0;
        next_applied_cnt = applied_cnt;
        next_dropped_cnt = dropped_cnt;
        if (cmd_strobe && !ctrl_en) begin
            next_dropped_cnt = dropped_cnt + `QDC_CNT_HALF'(1);
        end
        if (cmd_strobe && ctrl_en) begin
            next_applied_cnt = applied_cnt + `QDC_CNT_HALF'(1);
            for (int ch = 0; ch < CHANNELS; ch++) begin
                hit = (sel == 2'(ch));
                case (ld)
                    // [RULE1] single store
                    `QDC_LD_STORE: begin
                        if (hit) begin
                            next_in_reg[ch] = cmd.payload_bits;
                        end
                    end
                    // [RULE2] single transfer
                    `QDC_LD_XFER: begin
                        if (hit) begin
                            next_dac_code[ch] = in_reg[ch];
                            next_power_down[ch] = QDC_PD_ACTIVE;
                            next_out_update[ch] = 1'b1;
                        end
                    end
                    // [RULE3] single store and transfer
                    `QDC_LD_BOTH: begin
                        if (hit) begin
                            next_in_reg[ch] = cmd.payload_bits;
                            next_dac_code[ch] = cmd.payload_bits;
                            next_power_down[ch] = QDC_PD_ACTIVE;
                            next_out_update[ch] = 1'b1;
                        end
                    end
                    default: begin
                        case (sel)
                            // [RULE4] broadcast store
                            `QDC_BC_STORE: begin
                                next_in_reg[ch] = cmd.payload_bits;
                            end
                            // [RULE4] broadcast transfer
                            `QDC_BC_XFER: begin
                                next_dac_code[ch] = in_reg[ch];
                                next_power_down[ch] = QDC_PD_ACTIVE;
                                next_out_update[ch] = 1'b1;
                            end
                            // [RULE4] broadcast store and transfer
                            `QDC_BC_BOTH: begin
                                next_in_reg[ch] = cmd.payload_bits;
                                next_dac_code[ch] = cmd.payload_bits;
                                next_power_down[ch] = QDC_PD_ACTIVE;
                                next_out_update[ch] = 1'b1;
                            end
                            // [RULE5] power-down, registers untouched
                            default: begin
                                // [RULE8] all flag or channel field
                                if (cmd.payload_bits[`QDC_PD_ALL_BIT] ||
                                    cmd.payload_bits[`QDC_PD_CH_HI:`QDC_PD_CH_LO] == 2'(ch)) begin
                                    next_power_down[ch] =
                                        term_to_pd(cmd.payload_bits[`QDC_PD_TERM_HI:`QDC_PD_TERM_LO]);
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgl_seen <= 1'b0;
            in_reg <= '0;
            dac_code <= '0;
            power_down <= '{default: QDC_PD_ACTIVE};
            out_update <= '0;
            applied_cnt <= '0;
            dropped_cnt <= '0;
        end else begin
            tgl_seen <= tgl_sync;
            in_reg <= next_in_reg;
            dac_code <= next_dac_code;
            power_down <= next_power_down;
            out_update <= next_out_update;
            applied_cnt <= next_applied_cnt;
            dropped_cnt <= next_dropped_cnt;
        end
    end

    // ---------------- apb slave ----------------
    logic setup_rd;
    logic access_wr;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic slverr;
    logic next_slverr;
    logic [`QDC_ADDR_W-1:0] ch_base;
    logic [1:0] ch_idx;

    // [RULE6] registers are a local view only, the link has no read-back
    assign setup_rd = apb_req.psel & ~apb_req.penable;
    assign access_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign ch_base = apb_req.paddr & ~`QDC_CH_MASK;
    assign ch_idx = apb_req.paddr[`QDC_CH_LSB+1:`QDC_CH_LSB];

    // read mux and error decode, captured in the setup phase
    always_comb begin
        next_rdata = rdata;
        next_slverr = slverr;
        if (setup_rd) begin
            next_rdata = '0;
            next_slverr = 1'b0;
            if (apb_req.paddr == `QDC_OFS_CTRL) begin
                next_rdata[`QDC_CTRL_EN_BIT] = ctrl_en;
            end else if (apb_req.paddr == `QDC_OFS_STATUS) begin
                next_rdata[`QDC_STAT_BUSY_BIT] = ~busy_sync_n;
                for (int ch = 0; ch < CHANNELS; ch++) begin
                    if (power_down[ch] != QDC_PD_ACTIVE) begin
                        next_rdata[`QDC_STAT_PD_BIT] = 1'b1;
                    end
                end
            end else if (apb_req.paddr == `QDC_OFS_FRAMES) begin
                next_rdata = {dropped_cnt, applied_cnt};
            end else if (apb_req.paddr == `QDC_OFS_PDSTATE) begin
                for (int ch = 0; ch < CHANNELS; ch++) begin
                    next_rdata[ch*`QDC_PD_FIELD_W +: `QDC_PD_FIELD_W] = power_down[ch];
                end
            end else if (ch_base == `QDC_OFS_INREG0) begin
                next_rdata[DATA_W-1:0] = in_reg[ch_idx];
            end else if (ch_base == `QDC_OFS_DACREG0) begin
                next_rdata[DATA_W-1:0] = dac_code[ch_idx];
            end else begin
                next_slverr = 1'b1;
            end
            // only the control word accepts writes; others are ignored
            if (apb_req.pwrite) begin
                next_rdata = '0;
            end
        end
    end

    // control write, taken in the access phase
    always_comb begin
        next_ctrl_en = ctrl_en;
        if (access_wr && apb_req.paddr == `QDC_OFS_CTRL) begin
            next_ctrl_en = apb_req.pwdata[`QDC_CTRL_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= '0;
            slverr <= 1'b0;
            ctrl_en <= `QDC_CTRL_RST;
        end else begin
            rdata <= next_rdata;
            slverr <= next_slverr;
            ctrl_en <= next_ctrl_en;
        end
    end

    // zero wait state answer
    always_comb begin
        apb_rsp.prdata = rdata;
        apb_rsp.pready = 1'b1;
        apb_rsp.pslverr = slverr & apb_req.psel & apb_req.penable;
    end

endmodule

`default_nettype wire

// *** tb/qdc_top_monitor.sv ***
// port checker of the quad converter command decoder
`default_nettype none
module qdc_top_monitor #(
    parameter int CHANNELS = 4,
    parameter int DATA_W = 12,
    parameter int FRAME_BITS = 16
) (
    input wire logic pclk, // register clock
    input wire logic presetn, // async reset, active low
    input wire qdc_pkg::qdc_apb_req_t apb_req, // apb request
    input wire qdc_pkg::qdc_apb_rsp_t apb_rsp, // apb answer
    input wire logic sclk, // serial clock
    input wire logic sdata, // serial data
    input wire logic frame_sync_n, // frame sync, active low
    input wire qdc_pkg::qdc_code_t [CHANNELS-1:0] dac_code, // converter codes
    input wire qdc_pkg::qdc_pd_t [CHANNELS-1:0] power_down, // output states
    input wire logic [CHANNELS-1:0] out_update // load pulses
);
    timeunit 1ns;
    timeprecision 100ps;
    import qdc_pkg::*;
    // all checks run on the register clock
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // apb answers: no wait, error only in access, zeroed data
    AST_PREADY: assert property (apb_rsp.pready) else $error("pready low");
    AST_ERR_ACCESS: assert property (apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
        else $error("pslverr outside access");
    AST_ERR_ZERO: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == '0) else $error("error data not zero");
    AST_WR_ZERO: assert property (apb_req.psel && !apb_req.penable && apb_req.pwrite |=> apb_rsp.prdata == '0)
        else $error("write data not zero");
    AST_UPD_PULSE: assert property (|out_update |=> !(|out_update) [*4])
        else $error("load pulse too long");
    // codes move only with a load
    AST_DAC_CAUSE: assert property ($changed(dac_code) |-> |out_update)
        else $error("code changed without load");
    // per-channel state checks
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        AST_PD_ONEHOT: assert property ($onehot(power_down[i]))
            else $error("output state not one-hot");
        AST_UPD_ACTIVE: assert property (out_update[i] |-> power_down[i] == QDC_PD_ACTIVE)
            else $error("loaded channel not active");
    end
endmodule
`default_nettype wire

// *** tb/qdc_host_model.sv ***
// host controller model that drives the serial command link
`default_nettype none
module qdc_host_model (
    output var logic sclk, // serial clock, parked high
    output var logic sdata, // serial data
    output var logic frame_sync_n // frame sync, active low
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle link: clock parked, frame closed
    initial begin
        sclk = 1'b1;
        sdata = 1'b0;
        frame_sync_n = 1'b1;
    end
    // msb first, taken on falling clock
    task automatic send(input logic [15:0] w, input int n);
        // sync stays high between frames so the bit counter clears
        #24;
        frame_sync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdata = w[15 - i];
            #24 sclk = 1'b0;
            #24 sclk = 1'b1;
        end
        #10 frame_sync_n = 1'b1;
        sdata = ~sdata;
    endtask
endmodule
`default_nettype wire

// *** tb/test_quad_dac_serial_command_decoder.sv ***
// self-checking bench of the quad converter command decoder
`default_nettype none
`include "qdc_defines.svh"
module test_quad_dac_serial_command_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    import qdc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    qdc_apb_req_t apb_req = '0;
    qdc_apb_rsp_t apb_rsp;
    wire logic sclk;
    wire logic sdata;
    wire logic frame_sync_n;
    qdc_code_t [3:0] dac_code;
    qdc_pd_t [3:0] power_down;
    logic [3:0] out_update;
    int failures = 0;
    int check_count = 0;
    int execs = 0;
    int drops = 0;
    logic [11:0] in_m [4] = '{default: '0};
    logic [11:0] dac_m [4] = '{default: '0};
    logic [3:0] pd_m [4] = '{default: QDC_PD_ACTIVE};
    logic [3:0] upd_m = '0;
    logic [3:0] upd_seen = '0;
    logic [15:0] cmds [16] = '{16'h0111, 16'h1222, 16'h2333, 16'h3444, 16'h4000, 16'h9ABC, 16'h6000,
        16'hF6A5, 16'hF17F, 16'hF380, 16'hC5A5, 16'hD000, 16'hFE00, 16'hEFFF, 16'h2123, 16'hF4A5};

    // register clock
    always #12.5 pclk = ~pclk;

    qdc_top dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sclk(sclk),
        .sdata(sdata), .frame_sync_n(frame_sync_n), .dac_code(dac_code), .power_down(power_down),
        .out_update(out_update));
    qdc_host_model host (.sclk(sclk), .sdata(sdata), .frame_sync_n(frame_sync_n));

    // compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1) @(posedge pclk);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    // read a register and compare it
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp, r);
        chk("slverr", 32'h0, 32'(e));
    endtask

    // expected effect of one command
    task automatic apply(input logic [15:0] w);
        logic [3:0] st;
        st = (w[8:7] == `QDC_TERM_1K) ? QDC_PD_1K : (w[8:7] == `QDC_TERM_100K) ? QDC_PD_100K : QDC_PD_HIZ;
        execs++;
        upd_m = '0;
        for (int i = 0; i < 4; i++) begin
            if (w[15:14] == `QDC_LD_BCAST && w[13:12] == `QDC_BC_PWD) begin
                if (w[11] || w[10:9] == i) pd_m[i] = st;
            end else if (w[15:14] == `QDC_LD_BCAST || w[13:12] == i) begin
                if (w[13:12] != `QDC_BC_XFER || w[15:14] != `QDC_LD_BCAST) begin
                    if (w[15:14] != `QDC_LD_XFER) in_m[i] = w[11:0];
                end
                if ((w[15:14] == `QDC_LD_BCAST ? w[13:12] : w[15:14]) != `QDC_LD_STORE) begin
                    dac_m[i] = in_m[i];
                    pd_m[i] = QDC_PD_ACTIVE;
                    upd_m[i] = 1'b1;
                end
            end
        end
    endtask

    // compare every channel against the expected state
    task automatic check_all();
        logic [31:0] pds;
        pds = '0;
        for (int i = 0; i < 4; i++) begin
            chk("dac_code", 32'(dac_m[i]), 32'(dac_code[i]));
            chk("power_down", 32'(pd_m[i]), 32'(power_down[i]));
            rd_chk("inreg", `QDC_OFS_INREG0 + 12'(4 * i), 32'(in_m[i]));
            rd_chk("dacreg", `QDC_OFS_DACREG0 + 12'(4 * i), 32'(dac_m[i]));
            pds[4*i +: 4] = pd_m[i];
        end
        rd_chk("pdstate", `QDC_OFS_PDSTATE, pds);
        rd_chk("frames", `QDC_OFS_FRAMES, {16'(drops), 16'(execs)});
        chk("out_update", 32'(upd_m), 32'(upd_seen));
    endtask

    // send a full frame and let it settle
    task automatic frame(input logic [15:0] w);
        upd_seen = '0;
        host.send(w, 16);
        // each edge sees the pulse value that stood through the cycle before it
        repeat (10) begin
            @(posedge pclk);
            upd_seen |= out_update;
        end
    endtask

    // verdict and end of run
    task automatic summarize();
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        logic [31:0] r;
        logic e;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl", `QDC_OFS_CTRL, 32'h1);
        check_all();
        apb(1'b0, 12'h030, 32'h0, r, e);
        chk("slverr", 32'h1, 32'(e));
        chk("prdata", 32'h0, r);
        apb(1'b1, `QDC_OFS_DACREG0, 32'hFFF, r, e);
        chk("slverr", 32'h0, 32'(e));
        foreach (cmds[k]) begin
            frame(cmds[k]);
            apply(cmds[k]);
            check_all();
        end
        rd_chk("status", `QDC_OFS_STATUS, 32'h2);
        host.send(16'h2FFF, 12);
        frame(16'h0456);
        apply(16'h0456);
        check_all();
        apb(1'b1, `QDC_OFS_CTRL, 32'h0, r, e);
        frame(16'h8777);
        drops++;
        upd_m = '0;
        check_all();
        apb(1'b1, `QDC_OFS_CTRL, 32'h1, r, e);
        summarize();
    end

    // watchdog against a hang
    initial begin
        #300000;
        failures++;
        summarize();
    end
endmodule

bind qdc_top qdc_top_monitor #(.CHANNELS(CHANNELS), .DATA_W(DATA_W), .FRAME_BITS(FRAME_BITS)) mon (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sclk(sclk), .sdata(sdata),
    .frame_sync_n(frame_sync_n), .dac_code(dac_code), .power_down(power_down), .out_update(out_update));
`default_nettype wire
